//--- design/rsi_top.sv
/*
  reset state initialiser: tells apart power-on, low-supply and
  watchdog resets and applies flags and register images.
  assumes reset sources are synchronous; the core consumes the
  pc/sp clear and full init pulses on the following cycle.
*/
`default_nettype none
module rsi_top
  import rsi_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire rsi_src_t src,
  input wire logic sleeping,
  input wire logic sleepEntry,
  input wire logic swClearCause,
  input wire logic regWrEn,
  input wire rsi_regs_t regWrData,
  output logic [7:0] status,
  output logic lowSupplyCause,
  output logic fullInit,
  output logic pcSpClear,
  output logic [12:0] pc,
  output logic [2:0] sp,
  output logic watchdogClear,
  output logic timeBaseClear,
  output rsi_regs_t regs,
  output rsi_kind_t lastKind
);

  // ----------------------------------------
  // classification
  // ----------------------------------------
  rsi_kind_t kind;
  logic doFull;
  rsi_regs_t regVal;

  rsi_classify u_cls (
    .src(src),
    .sleeping(sleeping),
    .kind(kind)
  );

  // reset input acts as a power-on reset
  assign doFull = reset || kind == RSI_POR || kind == RSI_LOWSUP ||
    kind == RSI_WDOG_RUN;

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset || kind == RSI_POR) begin
      // RL2 power-on clears flags
      status <= STATUS_RST;
    end else begin
      unique case (kind)
        // RL3 flags kept on low supply
        RSI_LOWSUP: status <= status;
        // RL4 timeout set, powerdown kept
        RSI_WDOG_RUN: status[STAT_TMO_BIT] <= 1'b1;
        // RL5 both flags set
        RSI_WDOG_SLEEP: begin
          status[STAT_TMO_BIT] <= 1'b1;
          status[STAT_PWRDN_BIT] <= 1'b1;
        end
        RSI_NONE: begin
          if (sleepEntry) begin
            status[STAT_PWRDN_BIT] <= 1'b1;
          end
        end
        default: status <= status;
      endcase
    end
  end

  // ----------------------------------------
  // low-supply cause flag
  // ----------------------------------------
  // set beats software clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lowSupplyCause <= 1'b0;
    // RL13 set on real low supply
    end else if (kind == RSI_LOWSUP) begin
      lowSupplyCause <= 1'b1;
    end else if (swClearCause) begin
      lowSupplyCause <= 1'b0;
    end
  end

  // ----------------------------------------
  // reset pulses to the core
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    // RL12 run timeout is a full init
    fullInit <= doFull;
    // RL1 sleep timeout clears pc/sp only
    pcSpClear <= doFull || kind == RSI_WDOG_SLEEP;
    // RL7 clear watchdog and time bases
    watchdogClear <= doFull;
    timeBaseClear <= doFull;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lastKind <= RSI_POR;
    end else if (kind != RSI_NONE) begin
      lastKind <= kind;
    end
  end

  // ----------------------------------------
  // program counter and stack pointer images
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    // RL10 stack pointer at top
    if (doFull || kind == RSI_WDOG_SLEEP) begin
      pc <= PC_RST;
      sp <= SP_RST;
    end
  end

  // ----------------------------------------
  // peripheral register images
  // ----------------------------------------
  // sleep timeout leaves these untouched
  // RL9 ports become inputs
  rsi_hold_reg #(.INIT(PORT_DATA_RST)) u_pdat (
    .core_clk(core_clk), .fullInit(doFull), .wrEn(regWrEn),
    .wrData(regWrData.portData), .value(regVal.portData)
  );
  rsi_hold_reg #(.INIT(PORT_DIR_RST)) u_pdir (
    .core_clk(core_clk), .fullInit(doFull), .wrEn(regWrEn),
    .wrData(regWrData.portDir), .value(regVal.portDir)
  );
  // RL6 interrupts disabled
  rsi_hold_reg #(.INIT(INT_EN_RST)) u_inten (
    .core_clk(core_clk), .fullInit(doFull), .wrEn(regWrEn),
    .wrData(regWrData.intEnable), .value(regVal.intEnable)
  );
  // RL8 timers switched off
  rsi_hold_reg #(.INIT(TIMER_CTL_RST)) u_tmr (
    .core_clk(core_clk), .fullInit(doFull), .wrEn(regWrEn),
    .wrData(regWrData.timerCtl), .value(regVal.timerCtl)
  );
  rsi_hold_reg #(.INIT(WDOG_CTL_RST)) u_wdc (
    .core_clk(core_clk), .fullInit(doFull), .wrEn(regWrEn),
    .wrData(regWrData.watchdogCtl), .value(regVal.watchdogCtl)
  );
  rsi_hold_reg #(.INIT(LOWSUP_TIME_RST)) u_lvt (
    .core_clk(core_clk), .fullInit(doFull), .wrEn(regWrEn),
    .wrData(regWrData.lowSupTime), .value(regVal.lowSupTime)
  );

  // outputs straight from flip-flops
  always_ff @(posedge core_clk) begin
    regs <= regVal;
  end

endmodule
`default_nettype wire

//--- design/rsi_pkg.sv
/*
  shared constants and carriers for the reset state initialiser.
  assumes one synchronous clock domain; reset sources arrive as
  clock-synchronous one-cycle or level requests.
*/
// Functional notes
// RL1 - sleep timeout clears pc, sp; sets timeout
// RL2 - flags in status; power-on clears both
// RL3 - low-supply reset in run keeps flags
// RL4 - run timeout sets timeout, keeps powerdown
// RL5 - sleep timeout leaves both flags set
// RL6 - power-on disables every interrupt
// RL7 - power-on clears watchdog, time bases; restart
// RL8 - power-on switches all timers off
// RL9 - power-on makes all port pins inputs
// RL10 - power-on sets stack pointer to top
// RL11 - per-register values for each reset kind
// RL12 - run timeout equals power-on except flag
// RL13 - real low-supply reset sets cause flag
// RL14 - low-supply detection off in sleep/idle
// RL15 - power-on wins over other sources
`default_nettype none
package rsi_pkg;

  // ----------------------------------------
  // status register field positions
  // ----------------------------------------
  localparam int STAT_PWRDN_BIT = 4;
  localparam int STAT_TMO_BIT = 5;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] PORT_DATA_RST = 8'hff;
  localparam logic [7:0] PORT_DIR_RST = 8'hff;
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [7:0] TIMER_CTL_RST = 8'h00;
  localparam logic [7:0] WDOG_CTL_RST = 8'h53;
  localparam logic [7:0] LOWSUP_TIME_RST = 8'h01;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [2:0] SP_RST = 3'h0;

  // ----------------------------------------
  // reset kinds and carriers
  // ----------------------------------------
  typedef enum logic [2:0] {
    RSI_NONE, RSI_POR, RSI_LOWSUP, RSI_WDOG_RUN, RSI_WDOG_SLEEP
  } rsi_kind_t;

  typedef struct packed {
    logic powerOn;
    logic lowSupply;
    logic watchdogTimeout;
  } rsi_src_t;

  typedef struct packed {
    logic [7:0] portData;
    logic [7:0] portDir;
    logic [7:0] intEnable;
    logic [7:0] timerCtl;
    logic [7:0] watchdogCtl;
    logic [7:0] lowSupTime;
  } rsi_regs_t;

endpackage
`default_nettype wire

//--- design/rsi_classify.sv
/*
  decodes the active reset sources into one reset kind.
  assumes the sleep flag is a level valid in the same cycle.
*/
`default_nettype none
module rsi_classify
  import rsi_pkg::*;
(
  input wire rsi_src_t src,
  input wire logic sleeping,
  output rsi_kind_t kind
);

  always_comb begin
    kind = RSI_NONE;
    // RL15 power-on first
    if (src.powerOn) begin
      kind = RSI_POR;
    end else if (src.watchdogTimeout) begin
      kind = sleeping ? RSI_WDOG_SLEEP : RSI_WDOG_RUN;
    // RL14 detection gated in sleep
    end else if (src.lowSupply && !sleeping) begin
      kind = RSI_LOWSUP;
    end
  end

endmodule
`default_nettype wire

//--- design/rsi_hold_reg.sv
/*
  one 8-bit register that loads its reset image on a full reset.
  assumes software writes are single-cycle strobes.
*/
`default_nettype none
module rsi_hold_reg
  import rsi_pkg::*;
#(
  parameter logic [7:0] INIT = 8'h00
)(
  input wire logic core_clk,
  input wire logic fullInit,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] value
);

  // RL11 image on full reset
  always_ff @(posedge core_clk) begin
    if (fullInit) begin
      value <= INIT;
    end else if (wrEn) begin
      value <= wrData;
    end
  end

endmodule
`default_nettype wire

//--- sim/rsi_top_chk.sv
/*
  checker for the reset state initialiser top.
  assumes it is bound onto rsi_top and sees only its ports.
*/
`default_nettype none
module rsi_top_chk
  import rsi_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire rsi_src_t src,
  input wire logic sleeping,
  input wire logic swClearCause,
  input wire logic regWrEn,
  input wire logic [7:0] status,
  input wire logic lowSupplyCause,
  input wire logic fullInit,
  input wire logic pcSpClear,
  input wire logic [12:0] pc,
  input wire logic [2:0] sp,
  input wire logic watchdogClear,
  input wire logic timeBaseClear,
  input wire rsi_regs_t regs
);
  // ----------------------------------------
  // event sequences
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence sleepTo;
    src.watchdogTimeout && sleeping && !src.powerOn;
  endsequence
  sequence runTo;
    src.watchdogTimeout && !sleeping && !src.powerOn;
  endsequence
  // low-supply event in run mode only; ignored while asleep
  sequence lowSupRun;
    src.lowSupply && !src.watchdogTimeout && !src.powerOn && !sleeping;
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  AST_SLEEP_TO: assert property (sleepTo |=>
    status[5:4] == 2'b11 && pcSpClear && !fullInit && pc == 13'h0000
    && sp == 3'h0) else $error("sleep timeout wrong");
  AST_POR: assert property (src.powerOn |=>
    status == 8'h00 && fullInit && sp == SP_RST) else $error("por wrong");
  AST_LOWSUP_KEEP: assert property (lowSupRun |=>
    status == $past(status) && lowSupplyCause) else $error("lvr wrong");
  AST_RUN_TO: assert property (runTo |=>
    status[5] && status[4] == $past(status[4]) && fullInit)
    else $error("run timeout wrong");
  AST_LOWSUP_SLEEP: assert property (src.lowSupply && sleeping
    && !src.watchdogTimeout && !src.powerOn |=> !fullInit
    && lowSupplyCause == ($past(lowSupplyCause) && !$past(swClearCause)))
    else $error("lvr in sleep acted");
  AST_CAUSE_CLR: assert property (swClearCause && !src.lowSupply
    |=> !lowSupplyCause) else $error("cause not cleared");
  AST_CLR_PULSE: assert property (
    watchdogClear == fullInit && timeBaseClear == fullInit
    && fullInit == $past(reset || src.powerOn
    || (!sleeping && (src.watchdogTimeout || src.lowSupply))))
    else $error("clear pulses differ");
  // writes near an init are excluded, though rsi_hold_reg lets the full init win over a same-cycle write
  AST_IMAGE: assert property (fullInit && !regWrEn
    && !$past(regWrEn) |=> regs.intEnable == INT_EN_RST
    && regs.timerCtl == TIMER_CTL_RST && regs.portDir == PORT_DIR_RST)
    else $error("image wrong");
endmodule
bind rsi_top rsi_top_chk uChk (.core_clk, .reset, .src, .sleeping,
  .swClearCause, .regWrEn, .status, .lowSupplyCause, .fullInit,
  .pcSpClear, .pc, .sp, .watchdogClear, .timeBaseClear, .regs);
`default_nettype wire

//--- sim/tb_top.sv
/*
  directed testbench for rsi_top.
  assumes the checker is bound in; inputs change on falling edges.
*/
`default_nettype none
module tb_top
  import rsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // stimulus and outputs
  // ----------------------------------------
  localparam rsi_regs_t IMG = {PORT_DATA_RST, PORT_DIR_RST, INT_EN_RST,
    TIMER_CTL_RST, WDOG_CTL_RST, LOWSUP_TIME_RST};
  logic core_clk = 0, reset = 1, sleeping = 0, sleepEntry = 0;
  logic swClearCause = 0, regWrEn = 0;
  rsi_src_t src = '0;
  rsi_regs_t regWrData = '0, regs;
  logic [7:0] status;
  logic lowSupplyCause, fullInit, pcSpClear, watchdogClear, timeBaseClear;
  logic [12:0] pc;
  logic [2:0] sp;
  rsi_kind_t lastKind;
  int nMismatch = 0, numChecks = 0;
  rsi_top uut (.core_clk, .reset, .src, .sleeping, .sleepEntry,
    .swClearCause, .regWrEn, .regWrData, .status, .lowSupplyCause,
    .fullInit, .pcSpClear, .pc, .sp, .watchdogClear, .timeBaseClear,
    .regs, .lastKind);
  always #20 core_clk = ~core_clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one event cycle; its answer is settled at the next falling edge
  task step(input rsi_src_t s, input logic slp);
    src = s;
    sleeping = slp;
    @(negedge core_clk);
    src = '0;
  endtask
  task pulseSleep;
    sleepEntry = 1;
    @(negedge core_clk);
    sleepEntry = 0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task tPor;
    chk("status", status, 8'h00);
    chk("pcsp", {pc, sp}, 16'h0000);
    chk("regs", regs, IMG);
    chk("kind", lastKind, RSI_POR);
    pulseSleep();
    chk("pwrdn", status[4], 1'b1);
    step(3'b111, 0);
    chk("status", status, 8'h00);
    chk("clr", {watchdogClear, timeBaseClear, fullInit}, 3'b111);
  endtask
  task tSleepTo;
    regWrEn = 1;
    regWrData = 48'h0102_0304_0506;
    @(negedge core_clk);
    regWrEn = 0;
    repeat (2) @(negedge core_clk);
    step(3'b001, 1);
    chk("status", status, 8'h30);
    chk("pcs", {pcSpClear, fullInit}, 2'b10);
    @(negedge core_clk);
    chk("regs", regs, 48'h0102_0304_0506);
  endtask
  task tRunTo;
    step(3'b001, 0);
    chk("status", status, 8'h30);
    @(negedge core_clk);
    chk("regs", regs, IMG);
    step(3'b100, 0);
    step(3'b001, 0);
    chk("status", status, 8'h20);
    chk("kind", lastKind, RSI_WDOG_RUN);
  endtask
  task tLowSup;
    step(3'b010, 0);
    chk("status", status, 8'h20);
    chk("cause", lowSupplyCause, 1'b1);
    chk("full", fullInit, 1'b1);
    swClearCause = 1;
    @(negedge core_clk);
    chk("cause", lowSupplyCause, 1'b0);
    // clear still high: the new event must win
    step(3'b010, 0);
    chk("cause", lowSupplyCause, 1'b1);
    @(negedge core_clk);
    swClearCause = 0;
    chk("cause", lowSupplyCause, 1'b0);
    step(3'b110, 0);
    chk("cause", lowSupplyCause, 1'b0);
    chk("status", status, 8'h00);
    step(3'b010, 1);
    chk("lvs", {lowSupplyCause, fullInit}, 2'b00);
    sleeping = 0;
  endtask
  // reset pulled again mid-run with flags and a write pending
  task tReset;
    step(3'b010, 0);
    regWrEn = 1;
    regWrData = 48'h0a0b_0c0d_0e0f;
    pulseSleep();
    regWrEn = 0;
    reset = 1;
    @(negedge core_clk);
    reset = 0;
    chk("status", status, 8'h00);
    chk("cause", lowSupplyCause, 1'b0);
    chk("kind", lastKind, RSI_POR);
    chk("init", {fullInit, pcSpClear}, 2'b11);
    chk("regs", regs, 48'h0a0b_0c0d_0e0f);
    @(negedge core_clk);
    chk("regs", regs, IMG);
  endtask
  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task endOfTest;
    if (nMismatch == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    reset = 0;
    tPor();
    tSleepTo();
    tRunTo();
    tLowSup();
    tReset();
    endOfTest();
  end
  // the run needs about 40 cycles; this allows far more
  initial begin
    #200000;
    nMismatch++;
    endOfTest();
  end
endmodule
`default_nettype wire
